// ==== pe_pkg.sv ====
// Constants, field positions and mode types for the port E pin block.
// Assumes one 20 MHz clock and a plain address/strobe register port.
//
// Function
// [R1] USB on: pin 2 is D+, pullup selectable
// [R2] PS/2 on: pin 2 open-drain clock output
// [R3] Otherwise pin 2 open-drain GPIO, pullup choice
// [R4] USB owns pins 3,2; else open-drain
// [R5] Pin-3 interrupt: input, direction ignored
// [R6] Pin 3 GPIO input or open-drain output
// [R7] D+ pullup beats the 5k pullup
// [R8] USB on disconnects both 5k pullups
// [R9] SPI drives and directs pins 7 to 4
// [R10] Direction still picks latch or pin read
// [R11] Direction one enables output; reset clears
// [R12] Data read: latch if output, else pin
// [R13] Data writes always load the latch
// [R14] Software loads data before enabling output
// [R15] LED bits give port B high sink
// [R16] Port D pullup disables, enabled after reset
// [R17] D+ pullup enable connects 3.3 V pullup
// [R18] Pin 3/2 5k pullups when not USB
// [R19] Port B pullup enables, cleared by reset
// [R20] Pins 7-4 SPI, pins 3-2 USB
// [R21] Pin-3 interrupt forces pullup, feeds request
// [R22] Pad controls out, pad levels sampled
// [R23] Bus writes land next edge, low bits zero
package pe_pkg;

    // Bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [7:0] OFS_DATA       = 8'h08;
    localparam logic [7:0] OFS_DIR        = 8'h0c;
    localparam logic [7:0] OFS_LED        = 8'h1d;
    localparam logic [7:0] OFS_PULLOPT    = 8'h1e;
    localparam logic [7:0] OFS_PORTB_PULL = 8'h1f;
    localparam logic [7:0] OFS_FUNC       = 8'h20;

    // Reset values
    localparam logic [7:0] RST_ZERO       = 8'h00;

    // Implemented port E bits (7:2)
    localparam logic [7:0] PORT_MASK      = 8'hfc;

    // Pin positions
    localparam int PIN2    = 2;
    localparam int PIN3    = 3;
    localparam int SPI_LO  = 4;
    localparam int SPI_HI  = 7;

    // Pullup option fields
    localparam int PO_PIN2_WEAK = 0;
    localparam int PO_PIN3_WEAK = 1;
    localparam int PO_DPLUS     = 2;
    localparam int PO_PD2_OFF   = 5;
    localparam int PO_PD3_OFF   = 6;
    localparam int PO_PD7_OFF   = 7;

    // Function select fields
    localparam int FN_USB      = 0;
    localparam int FN_PS2      = 1;
    localparam int FN_SPI      = 2;
    localparam int FN_PIN3_IRQ = 3;
    localparam logic [7:0] FUNC_MASK = 8'h0f;

    // Pin modes
    typedef enum logic [1:0] {P2_USB, P2_PS2, P2_GPIO} pe_pin2_mode_t;
    typedef enum logic [1:0] {P3_USB, P3_IRQ, P3_GPIO} pe_pin3_mode_t;

endpackage : pe_pkg

// ==== pe_port_e.sv ====
// Port E pin mux, data/direction registers and the port option registers.
// Assumes pads resolve oe/out into the wire, and USB, PS/2 and SPI blocks
// run on the same clock as this block.
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps

module pe_port_e
    import pe_pkg::*;
#(
    parameter int DWIDTH = DATA_W
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // Register port
    input  wire logic [7:0]  bus_addr,
    input  wire logic [7:0]  bus_wdata,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    output logic      [7:0]  bus_rdata,
    // Peer functions, same clock
    input  wire logic        ps2_clk_level,
    input  wire logic [3:0]  spi_pad_out,
    input  wire logic [3:0]  spi_pad_oe,
    // Port E pads
    input  wire logic [7:0]  pad_in,
    output logic      [7:0]  pad_out,
    output logic      [7:0]  pad_oe,
    // Pin 2/3 pullup and USB controls
    output logic             pin2_pullup_5k,
    output logic             pin2_pullup_1k2,
    output logic             pin3_pullup_5k,
    output logic             dplus_pullup_3v3,
    output logic             usb_pins_owned,
    output logic             pin3_irq_req,
    // Port B and port D options
    output logic      [7:0]  portb_led_drive,
    output logic      [7:0]  portb_pullup_on,
    output logic      [2:0]  portd_pullup_on
);

    // Parameter check
    if (DWIDTH != 8) begin : g_bad_width
        $error("pe_port_e supports an 8-bit data path only");
    end

    // Software registers
    logic [7:0] port_e_latch_reg;
    logic [7:0] port_e_direction_bits_reg;
    logic [7:0] led_drive_options_reg;
    logic [7:0] pullup_options_reg;
    logic [7:0] portb_pullup_reg;
    logic [7:0] func_select_reg;
    logic [7:0] rdata_reg;

    // Pin input filter
    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic [7:0] sync3_reg;
    logic [7:0] pin_level_reg;
    logic [7:0] pin_level_next;

    // Registered pad controls
    logic [7:0] pad_out_reg;
    logic [7:0] pad_oe_reg;
    logic       pin2_5k_reg;
    logic       pin2_1k2_reg;
    logic       pin3_5k_reg;
    logic       dplus_3v3_reg;
    logic       usb_owned_reg;
    logic       irq_req_reg;
    logic [2:0] portd_pu_reg;

    // Decoded control bits
    wire logic usb_module_on       = func_select_reg[FN_USB];
    wire logic ps2_clockgen_on     = func_select_reg[FN_PS2];
    wire logic spi_function_on     = func_select_reg[FN_SPI];
    wire logic pin3_irq_on         = func_select_reg[FN_PIN3_IRQ];
    wire logic pin2_weak_pullup_on = pullup_options_reg[PO_PIN2_WEAK];
    wire logic pin3_weak_pullup_on = pullup_options_reg[PO_PIN3_WEAK];
    wire logic dplus_pullup_on     = pullup_options_reg[PO_DPLUS];

    // Address decode
    wire logic sel_data  = (bus_addr == OFS_DATA);
    wire logic sel_dir   = (bus_addr == OFS_DIR);
    wire logic sel_led   = (bus_addr == OFS_LED);
    wire logic sel_popt  = (bus_addr == OFS_PULLOPT);
    wire logic sel_pbpu  = (bus_addr == OFS_PORTB_PULL);
    wire logic sel_func  = (bus_addr == OFS_FUNC);

    // [R13] latch always writable
    wire logic [7:0] latch_next = (bus_wr && sel_data) ? (bus_wdata & PORT_MASK) : port_e_latch_reg;
    // [R11] direction bits, six implemented
    wire logic [7:0] dir_next   = (bus_wr && sel_dir) ? (bus_wdata & PORT_MASK) : port_e_direction_bits_reg;
    // [R15] LED drive bits
    wire logic [7:0] led_next   = (bus_wr && sel_led) ? bus_wdata : led_drive_options_reg;
    // [R16] pullup option bits
    wire logic [7:0] popt_next  = (bus_wr && sel_popt) ? bus_wdata : pullup_options_reg;
    // [R19] port B pullup enables
    wire logic [7:0] pbpu_next  = (bus_wr && sel_pbpu) ? bus_wdata : portb_pullup_reg;
    wire logic [7:0] func_next  = (bus_wr && sel_func) ? (bus_wdata & FUNC_MASK) : func_select_reg;

    // [R12] per-bit latch or pin; [R10] same under SPI
    wire logic [7:0] data_view = ((port_e_direction_bits_reg & port_e_latch_reg)
                                 | (~port_e_direction_bits_reg & pin_level_reg)) & PORT_MASK;

    // Read multiplexer, unmapped reads return zero
    wire logic [7:0] rd_mux = sel_data ? data_view :
                              sel_dir  ? port_e_direction_bits_reg :
                              sel_led  ? led_drive_options_reg :
                              sel_popt ? pullup_options_reg :
                              sel_pbpu ? portb_pullup_reg :
                              sel_func ? func_select_reg : RST_ZERO;
    wire logic [7:0] rdata_next = bus_rd ? rd_mux : RST_ZERO;

    // Register bank
    // [R23] writes land on the next edge
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            port_e_latch_reg          <= RST_ZERO;
            port_e_direction_bits_reg <= RST_ZERO;
            led_drive_options_reg     <= RST_ZERO;
            pullup_options_reg        <= RST_ZERO;
            portb_pullup_reg          <= RST_ZERO;
            func_select_reg           <= RST_ZERO;
            rdata_reg                 <= RST_ZERO;
        end else begin
            port_e_latch_reg          <= latch_next;
            port_e_direction_bits_reg <= dir_next;
            led_drive_options_reg     <= led_next;
            pullup_options_reg        <= popt_next;
            portb_pullup_reg          <= pbpu_next;
            func_select_reg           <= func_next;
            rdata_reg                 <= rdata_next;
        end
    end

    // [R22] level changes once stages two and three agree
    assign pin_level_next = (sync3_reg & ~(sync2_reg ^ sync3_reg))
                          | (pin_level_reg & (sync2_reg ^ sync3_reg));

    // Pad input synchroniser and filter
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_reg     <= RST_ZERO;
            sync2_reg     <= RST_ZERO;
            sync3_reg     <= RST_ZERO;
            pin_level_reg <= RST_ZERO;
        end else begin
            sync1_reg     <= pad_in;
            sync2_reg     <= sync1_reg;
            sync3_reg     <= sync2_reg;
            pin_level_reg <= pin_level_next;
        end
    end

    // Pin function priority, USB first
    pe_pin2_mode_t pin2_mode;
    pe_pin3_mode_t pin3_mode;
    // [R1] [R2] [R3] pin 2 priority
    assign pin2_mode = usb_module_on ? P2_USB : (ps2_clockgen_on ? P2_PS2 : P2_GPIO);
    // [R5] [R6] pin 3 priority
    assign pin3_mode = usb_module_on ? P3_USB : (pin3_irq_on ? P3_IRQ : P3_GPIO);

    // Pad drive for all port E pins
    logic [7:0] oe_next;
    logic [7:0] out_next;
    logic       p2_5k_next;
    logic       p2_1k2_next;
    logic       p3_5k_next;
    logic       dp_3v3_next;
    always_comb begin
        // [R11] push-pull pins follow the direction bits
        oe_next     = port_e_direction_bits_reg & PORT_MASK;
        out_next    = port_e_latch_reg & PORT_MASK;
        p2_5k_next  = 1'b0;
        p2_1k2_next = 1'b0;
        p3_5k_next  = 1'b0;
        dp_3v3_next = 1'b0;
        // [R9] [R20] SPI takes pins 7 to 4
        if (spi_function_on) begin
            oe_next[SPI_HI:SPI_LO]  = spi_pad_oe;
            out_next[SPI_HI:SPI_LO] = spi_pad_out;
        end
        // Open-drain pins only ever drive low
        out_next[PIN2] = 1'b0;
        out_next[PIN3] = 1'b0;
        case (pin2_mode)
            // [R1] [R17] D+ pad, port drive off
            P2_USB: begin
                oe_next[PIN2] = 1'b0;
                dp_3v3_next   = dplus_pullup_on;
            end
            // [R2] PS/2 clock pulls low only
            P2_PS2: begin
                oe_next[PIN2] = ~ps2_clk_level;
                p2_1k2_next   = dplus_pullup_on;
                // [R7] D+ enable wins over 5k
                p2_5k_next    = pin2_weak_pullup_on & ~dplus_pullup_on;
            end
            // [R3] [R4] open-drain GPIO
            P2_GPIO: begin
                oe_next[PIN2] = port_e_direction_bits_reg[PIN2] & ~port_e_latch_reg[PIN2];
                p2_1k2_next   = dplus_pullup_on;
                // [R7] [R18] 5k only without D+ enable
                p2_5k_next    = pin2_weak_pullup_on & ~dplus_pullup_on;
            end
            default: begin
                oe_next[PIN2] = 1'b0;
            end
        endcase
        case (pin3_mode)
            // [R8] USB: both 5k pullups out
            P3_USB: begin
                oe_next[PIN3] = 1'b0;
            end
            // [R5] [R21] input, pullup forced on
            P3_IRQ: begin
                oe_next[PIN3] = 1'b0;
                p3_5k_next    = 1'b1;
            end
            // [R6] [R18] open-drain GPIO, optional 5k
            P3_GPIO: begin
                oe_next[PIN3] = port_e_direction_bits_reg[PIN3] & ~port_e_latch_reg[PIN3];
                p3_5k_next    = pin3_weak_pullup_on;
            end
            default: begin
                oe_next[PIN3] = 1'b0;
            end
        endcase
    end

    // [R21] low pin 3 requests the interrupt
    wire logic irq_next = (pin3_mode == P3_IRQ) & ~pin_level_reg[PIN3];

    // [R16] disable bits inverted, pins 7,3,2
    wire logic [2:0] portd_pu_next = ~{pullup_options_reg[PO_PD7_OFF],
                                      pullup_options_reg[PO_PD3_OFF],
                                      pullup_options_reg[PO_PD2_OFF]};

    // Registered pad controls
    // [R22] pad controls from flops
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pad_out_reg   <= RST_ZERO;
            pad_oe_reg    <= RST_ZERO;
            pin2_5k_reg   <= 1'b0;
            pin2_1k2_reg  <= 1'b0;
            pin3_5k_reg   <= 1'b0;
            dplus_3v3_reg <= 1'b0;
            usb_owned_reg <= 1'b0;
            irq_req_reg   <= 1'b0;
            portd_pu_reg  <= '1;            // Port D pullups on after reset
        end else begin
            pad_out_reg   <= out_next;
            pad_oe_reg    <= oe_next;
            pin2_5k_reg   <= p2_5k_next;
            pin2_1k2_reg  <= p2_1k2_next;
            pin3_5k_reg   <= p3_5k_next;
            dplus_3v3_reg <= dp_3v3_next;
            usb_owned_reg <= usb_module_on;
            irq_req_reg   <= irq_next;
            portd_pu_reg  <= portd_pu_next;
        end
    end

    // Output wiring
    assign bus_rdata        = rdata_reg;
    assign pad_out          = pad_out_reg;
    assign pad_oe           = pad_oe_reg;
    assign pin2_pullup_5k   = pin2_5k_reg;
    assign pin2_pullup_1k2  = pin2_1k2_reg;
    assign pin3_pullup_5k   = pin3_5k_reg;
    assign dplus_pullup_3v3 = dplus_3v3_reg;
    // [R4] USB transceiver owns pins 3,2
    assign usb_pins_owned   = usb_owned_reg;
    assign pin3_irq_req     = irq_req_reg;
    // [R15] LED drive straight from its register
    assign portb_led_drive  = led_drive_options_reg;
    // [R19] port B pullups
    assign portb_pullup_on  = portb_pullup_reg;
    // [R16] port D pullup enables
    assign portd_pullup_on  = portd_pu_reg;

    // Checks on the pin mux and register port
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_data_write;
        bus_wr && sel_data;
    endsequence

    sequence s_data_read;
        bus_rd && sel_data;
    endsequence

    sequence s_pin3_low_irq;
        (pin3_mode == P3_IRQ) && !pin_level_reg[PIN3];
    endsequence

    a_usb_dplus_pull: assert property ( // [R1]
        usb_module_on |=> !pad_oe[PIN2] && dplus_pullup_3v3 == $past(dplus_pullup_on) && !pin2_pullup_1k2)
        else $error("pin 2 not held as D+ while USB on");

    a_ps2_clock_od: assert property ( // [R2]
        (!usb_module_on && ps2_clockgen_on) |=> pad_oe[PIN2] == !$past(ps2_clk_level) && !pad_out[PIN2])
        else $error("PS/2 clock drive wrong on pin 2");

    a_gpio2_open_drain: assert property ( // [R3]
        (pin2_mode == P2_GPIO) |=> pad_oe[PIN2] == ($past(port_e_direction_bits_reg[PIN2])
                                   && !$past(port_e_latch_reg[PIN2])))
        else $error("pin 2 GPIO open-drain drive wrong");

    a_usb_pins_free: assert property ( // [R4]
        usb_module_on ##1 usb_module_on |-> usb_pins_owned && pad_oe[PIN3:PIN2] == 2'b00)
        else $error("port drives USB pins while USB on");

    a_pin3_irq_input: assert property ( // [R5]
        (pin3_mode == P3_IRQ) |=> !pad_oe[PIN3] && pin3_pullup_5k)
        else $error("pin 3 not input in interrupt mode");

    a_gpio3_open_drain: assert property ( // [R6]
        (pin3_mode == P3_GPIO) |=> pad_oe[PIN3] == ($past(port_e_direction_bits_reg[PIN3])
                                   && !$past(port_e_latch_reg[PIN3]))
                                   && pin3_pullup_5k == $past(pin3_weak_pullup_on))
        else $error("pin 3 GPIO drive or pullup wrong");

    a_dplus_beats_5k: assert property ( // [R7]
        (!usb_module_on && dplus_pullup_on) |=> pin2_pullup_1k2 && !pin2_pullup_5k)
        else $error("5k pullup active beside D+ pullup");

    a_usb_no_weak: assert property ( // [R8]
        usb_module_on |=> !pin2_pullup_5k && !pin3_pullup_5k)
        else $error("5k pullups connected while USB on");

    a_spi_override: assert property ( // [R9]
        spi_function_on |=> pad_oe[SPI_HI:SPI_LO] == $past(spi_pad_oe)
                            && pad_out[SPI_HI:SPI_LO] == $past(spi_pad_out))
        else $error("SPI pins not under SPI control");

    a_data_read_mux: assert property ( // [R12]
        s_data_read |=> bus_rdata == (($past(port_e_direction_bits_reg) & $past(port_e_latch_reg))
                                     | (~$past(port_e_direction_bits_reg) & $past(pin_level_reg) & PORT_MASK)))
        else $error("port data read mixes latch and pin wrongly");

    a_data_write_latch: assert property ( // [R13]
        s_data_write |=> port_e_latch_reg == ($past(bus_wdata) & PORT_MASK)
                         && ((data_view ^ pin_level_reg) & ~port_e_direction_bits_reg & PORT_MASK) == RST_ZERO)
        else $error("data write lost or disturbed input");

    a_irq_follows_pin: assert property ( // [R21]
        s_pin3_low_irq |=> pin3_irq_req)
        else $error("pin 3 low level gave no interrupt request");

    a_rdata_one_cycle: assert property ( // [R23]
        !bus_rd |=> bus_rdata == RST_ZERO)
        else $error("read data stands outside its cycle");

    a_low_bits_zero: assert property ( // [R23]
        s_data_read |=> (bus_rdata & ~PORT_MASK) == RST_ZERO)
        else $error("unimplemented port bits read nonzero");

    a_dir_drives_pins: assert property ( // [R11]
        !spi_function_on |=> pad_oe[SPI_HI:SPI_LO] == $past(port_e_direction_bits_reg[SPI_HI:SPI_LO]))
        else $error("pins 7 to 4 ignore their direction bits");

    a_pin_filter_agree: assert property ( // [R22]
        1'b1 |=> (($past(sync2_reg ~^ sync3_reg)) & (pin_level_reg ^ $past(sync3_reg))) == RST_ZERO
                 && (($past(sync2_reg ^ sync3_reg)) & (pin_level_reg ^ $past(pin_level_reg))) == RST_ZERO)
        else $error("filtered pin level moved without stage agreement");

    a_portd_pullups: assert property ( // [R16]
        1'b1 |=> portd_pullup_on == ~$past({pullup_options_reg[PO_PD7_OFF],
                                            pullup_options_reg[PO_PD3_OFF],
                                            pullup_options_reg[PO_PD2_OFF]}))
        else $error("port D pullup enables not inverse of disable bits");

endmodule : pe_port_e

// ==== pe_pad_model.sv ====
// Pad model: resolves the port E wires from block drive, pullups and bench drive.
// Assumes the bench drives every pin it does not release through ext_drv/ext_val.
`timescale 1ns/100ps

module pe_pad_model (
    // Clock
    input  wire logic       mclk,
    // Block side
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe,
    input  wire logic       pu2,
    input  wire logic       pu3,
    // Bench side
    input  wire logic [7:0] ext_drv,
    input  wire logic [7:0] ext_val,
    // Resolved levels
    output logic      [7:0] pad_in
);
    logic       flip_reg = 1'b0;
    logic [7:0] pu_w;

    // Floating pins wander each cycle so no stale level passes
    always_ff @(posedge mclk) begin
        flip_reg <= ~flip_reg;
    end

    assign pu_w = {4'h0, pu3, pu2, 2'h0};

    // wire level seen by the pad inputs
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad_oe[i])
                pad_in[i] = pad_out[i];
            else if (ext_drv[i])
                pad_in[i] = ext_val[i];
            else if (pu_w[i])
                pad_in[i] = 1'b1;
            else
                pad_in[i] = flip_reg;
        end
    end
endmodule : pe_pad_model

// ==== test_port_e_pin_mux_and_options.sv ====
// Self-checking bench for the port E pin mux and option registers.
// Assumes pe_pad_model stands at the pads; bench plays CPU and peers.
`timescale 1ns/100ps

module test_port_e_pin_mux_and_options import pe_pkg::*;;
    logic [7:0]  bus_addr, bus_wdata, bus_rdata, pad_in, pad_out, pad_oe, v;
    logic        mclk, reset_n, bus_wr, bus_rd, ps2_clk_level;
    logic [3:0]  spi_pad_out, spi_pad_oe;
    logic        p2_5k, p2_1k2, p3_5k, dp33, owned, irq_req;
    logic [7:0]  led, pullb, ext_drv, ext_val;
    logic [2:0]  pdpu;
    logic [15:0] lf;
    int          num_errors, n_tests, cyc = 0;
    int          m_dat, m_dir, m_led, m_po, m_pb, m_fn;
    logic [7:0]  regs[6] = '{OFS_DIR, OFS_LED, OFS_PULLOPT, OFS_PORTB_PULL, OFS_FUNC, 8'h55};

    pe_port_e dut (
        .mclk(mclk), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .ps2_clk_level(ps2_clk_level), .spi_pad_out(spi_pad_out), .spi_pad_oe(spi_pad_oe),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pin2_pullup_5k(p2_5k), .pin2_pullup_1k2(p2_1k2), .pin3_pullup_5k(p3_5k),
        .dplus_pullup_3v3(dp33), .usb_pins_owned(owned), .pin3_irq_req(irq_req),
        .portb_led_drive(led), .portb_pullup_on(pullb), .portd_pullup_on(pdpu));

    pe_pad_model pads (
        .mclk(mclk), .pad_out(pad_out), .pad_oe(pad_oe), .pu2(p2_5k | p2_1k2 | dp33),
        .pu3(p3_5k), .ext_drv(ext_drv), .ext_val(ext_val), .pad_in(pad_in));

    // Expected pad drive and wire levels
    function automatic void model(output logic [7:0] oe, od, lv);
        logic u;
        u = m_fn[FN_USB];
        oe = 8'h00;
        od = 8'h00;
        oe[7:4] = m_fn[FN_SPI] ? spi_pad_oe : m_dir[7:4];
        od[7:4] = m_fn[FN_SPI] ? spi_pad_out : m_dat[7:4];
        oe[2] = !u && (m_fn[FN_PS2] ? !ps2_clk_level : (m_dir[2] && !m_dat[2]));
        oe[3] = !u && !m_fn[FN_PIN3_IRQ] && m_dir[3] && !m_dat[3];
        lv = (oe & od) | (~oe & ext_drv & ext_val) | (~oe & ~ext_drv);
    endfunction : model

    function automatic logic [7:0] rexp(input logic [7:0] a);
        logic [7:0] oe, od, lv;
        model(oe, od, lv);
        case (a)
            OFS_DATA:       return 8'((m_dir & m_dat) | (~m_dir & lv)) & PORT_MASK;
            OFS_DIR:        return 8'(m_dir);
            OFS_LED:        return 8'(m_led);
            OFS_PULLOPT:    return 8'(m_po);
            OFS_PORTB_PULL: return 8'(m_pb);
            OFS_FUNC:       return 8'(m_fn);
            default:        return 8'h00;
        endcase
    endfunction : rexp

    task automatic rnd(output logic [7:0] r);
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        r = lf[7:0];
    endtask : rnd

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge mclk);
        bus_wr <= 1'b0;
        case (a)
            OFS_DATA:       m_dat = d & PORT_MASK;
            OFS_DIR:        m_dir = d & PORT_MASK;
            OFS_LED:        m_led = d;
            OFS_PULLOPT:    m_po = d;
            OFS_PORTB_PULL: m_pb = d;
            OFS_FUNC:       m_fn = d & FUNC_MASK;
            default:        ;
        endcase
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge mclk);
        bus_rd <= 1'b0;
        #10;
        chk(bus_rdata, e);
    endtask : rd

    // Let pads settle and compare every output with the model
    task automatic check_all();
        logic [7:0] oe, od, lv, pu;
        logic       u;
        repeat (6) @(posedge mclk);
        #10;
        model(oe, od, lv);
        u = m_fn[FN_USB];
        pu = {2'b00, ~u & m_po[PO_PIN2_WEAK] & ~m_po[PO_DPLUS], ~u & m_po[PO_DPLUS],
              ~u & (m_po[PO_PIN3_WEAK] | m_fn[FN_PIN3_IRQ]), u & m_po[PO_DPLUS], u,
              ~u & m_fn[FN_PIN3_IRQ] & ~lv[3]};
        chk(pad_oe, oe);
        chk(pad_out & pad_oe, od & oe);
        chk({2'b00, p2_5k, p2_1k2, p3_5k, dp33, owned, irq_req}, pu);
        chk(led, 8'(m_led));
        chk(pullb, 8'(m_pb));
        chk({5'h0, pdpu}, {5'h0, ~m_po[PO_PD7_OFF], ~m_po[PO_PD3_OFF], ~m_po[PO_PD2_OFF]});
        rd(OFS_DATA, rexp(OFS_DATA));
    endtask : check_all

    task automatic wrap_up();
        $display("Checks run: %0d, errors: %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up

    // Clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            num_errors++;
            wrap_up();
        end
    end

    // Main sequence
    initial begin
        {reset_n, bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
        {spi_pad_out, spi_pad_oe, ps2_clk_level} = 9'h001;
        ext_drv = 8'hff;
        ext_val = 8'ha4;
        lf = 16'd5778;
        {num_errors, n_tests, m_dat, m_dir, m_led, m_po, m_pb, m_fn} = '0;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        check_all();
        foreach (regs[i]) rd(regs[i], 8'h00);
        wr(OFS_DATA, 8'h5b);
        rd(OFS_DATA, rexp(OFS_DATA));
        // Latch loaded before outputs turn on
        wr(OFS_DIR, 8'hff);
        check_all();
        // Every function mode, with both pullup patterns
        for (int f = 0; f < 32; f++) begin
            wr(OFS_PULLOPT, f[4] ? 8'he7 : 8'h21);
            wr(OFS_FUNC, 8'(f[3:0]));
            rnd(v);
            {spi_pad_out, spi_pad_oe} <= v;
            ps2_clk_level <= lf[9];
            rd(OFS_FUNC, rexp(OFS_FUNC));
            check_all();
        end
        // Pin 3 interrupt mode ignores direction and pulls up
        wr(OFS_PULLOPT, 8'h00);
        wr(OFS_FUNC, 8'h08);
        wr(OFS_DIR, 8'h08);
        wr(OFS_DATA, 8'h00);
        ext_val[3] <= 1'b0;
        check_all();
        ext_drv[3] <= 1'b0;
        check_all();
        ext_drv <= 8'hff;
        // Random register traffic, one idle cycle between accesses, with unmapped reads
        for (int k = 0; k < 12; k++) begin
            for (int j = 0; j < 5; j++) begin
                rnd(v);
                wr(regs[j], regs[j] == OFS_PULLOPT ? v & 8'he7 : v);
            end
            rnd(v);
            ext_val <= v;
            rnd(v);
            wr(OFS_DATA, v);
            foreach (regs[j]) rd(regs[j], rexp(regs[j]));
            check_all();
        end
        wrap_up();
    end
endmodule : test_port_e_pin_mux_and_options
